// file: common/fcs_map.svh
// fcs_map.svh: offsets, field positions, codes and timing counts of the flash host controller
// assumes: included by the package and the core; definitions only
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// wishbone register offsets (byte addresses)
`define FCS_REG_CTRL      4'h0
`define FCS_REG_ADDR      4'h4
`define FCS_REG_DATA      4'h8
`define FCS_REG_STAT      4'hc
// control register fields
`define FCS_CTRL_GO       8
`define FCS_CTRL_OP_LSB   0
`define FCS_CTRL_OP_MSB   2
// status register fields
`define FCS_STAT_BUSY     0
`define FCS_STAT_DONE     1
`define FCS_STAT_FAIL     2
`define FCS_STAT_TMO      3
`define FCS_STAT_RD_LSB   8
// flash unlock addresses and command codes
`define FCS_UNLOCK_A1     19'h05555
`define FCS_UNLOCK_A2     19'h02aaa
`define FCS_UNLOCK_D1     8'haa
`define FCS_UNLOCK_D2     8'h55
`define FCS_CMD_RESET     8'hf0
`define FCS_CMD_AUTOSEL   8'h90
`define FCS_CMD_PROGRAM   8'ha0
`define FCS_CMD_ESETUP    8'h80
`define FCS_CMD_CHIP      8'h10
`define FCS_CMD_SECTOR    8'h30
`define FCS_CMD_SUSPEND   8'hb0
`define FCS_CMD_RESUME    8'h30
// status bit positions on the flash data bus
`define FCS_POLL_BIT      7
`define FCS_TLIM_BIT      5
// timing: clock period in ps, sector erase window in ns, strobe phase in cycles
`define FCS_CLK_PS        25000
`define FCS_WIN_NS        80000
`define FCS_WIN_CYC       ((`FCS_WIN_NS * 1000) / `FCS_CLK_PS)
`define FCS_GAP_CYC       10
`define FCS_POLL_LIMIT    32'd400000000
`endif

// file: common/fcs_pkg.sv
// fcs_pkg.sv: types of the flash host controller
// assumes: fcs_map.svh sits beside it
`include "fcs_map.svh"
package fcs_pkg;
	// operations software can order
	typedef enum logic [2:0] {
		FCS_OP_READ, FCS_OP_RESET, FCS_OP_ID, FCS_OP_PROG,
		FCS_OP_CHIP, FCS_OP_SECT, FCS_OP_SUSP, FCS_OP_RESUME
	} fcs_op_t;
	// flash pin bundle driven by the controller
	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic [18:0] addr;
		logic [7:0]  dout;
		logic        doe;
	} fcs_pins_t;
endpackage : fcs_pkg

// file: core/fcs_host.sv
// fcs_host.sv: wishbone-driven host that sequences commands into a byte-wide parallel flash
// assumes: 40 MHz clk_i, synchronous reset, flash data pins resolved by the bench from doe
`timescale 1ns/1ps
`include "fcs_map.svh"

// What this block does
// - leave id mode by reset sequence
// - program uses four write cycles
// - poll program location until bit matches
// - chip erase uses six write cycles
// - one sector per erase order; no sectors added within the 80 us window
// - suspend/resume as one write to address 0, no poll; orders ignored while an erase is polled
// - keep sector writes back to back
// - unlock AA at 5555, 55 at 2AAA
module fcs_host (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [3:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// flash pins
	output fcs_pkg::fcs_pins_t      flash_o,
	input  wire logic [7:0]         flash_dq_i
);
	import fcs_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP, S_POLL} fcs_state_t;

	// builds the bus-cycle word for step n of an operation; returns {last, rd, addr, data}
	function automatic logic [28:0] step_word(input fcs_op_t op, input logic [2:0] n,
			input logic [18:0] a, input logic [7:0] d);
		logic [18:0] sect_loc;
		logic [7:0]  cd;
		sect_loc = a;
		cd = 8'h00;
		step_word = {1'b0, 1'b0, 19'h00000, 8'h00};
		case (n)
			3'd0: step_word = {2'b00, `FCS_UNLOCK_A1, `FCS_UNLOCK_D1};
			3'd1: step_word = {2'b00, `FCS_UNLOCK_A2, `FCS_UNLOCK_D2};
			3'd3: step_word = {2'b00, `FCS_UNLOCK_A1, `FCS_UNLOCK_D1};
			3'd4: step_word = {2'b00, `FCS_UNLOCK_A2, `FCS_UNLOCK_D2};
			default: step_word = {1'b0, 1'b0, 19'h00000, 8'h00};
		endcase
		case (op)
			FCS_OP_RESET:  cd = `FCS_CMD_RESET;
			FCS_OP_ID:     cd = `FCS_CMD_AUTOSEL;
			FCS_OP_PROG:   cd = `FCS_CMD_PROGRAM;
			default:       cd = `FCS_CMD_ESETUP;
		endcase
		if (n == 3'd2)
			step_word = {(op == FCS_OP_RESET || op == FCS_OP_ID), 1'b0, `FCS_UNLOCK_A1, cd};
		// fourth write carries location and value
		if (op == FCS_OP_PROG && n == 3'd3)
			step_word = {2'b10, a, d};
		if (op == FCS_OP_CHIP && n == 3'd5)
			step_word = {2'b10, `FCS_UNLOCK_A1, `FCS_CMD_CHIP};
		// sector address, one sector per order
		if (op == FCS_OP_SECT && n == 3'd5)
			step_word = {2'b10, sect_loc, `FCS_CMD_SECTOR};
		if (op == FCS_OP_SUSP)
			step_word = {2'b10, 19'h00000, `FCS_CMD_SUSPEND};
		if (op == FCS_OP_RESUME)
			step_word = {2'b10, 19'h00000, `FCS_CMD_RESUME};
		// plain array or id read, one cycle
		if (op == FCS_OP_READ)
			step_word = {2'b11, a, 8'h00};
	endfunction : step_word

	// registers
	fcs_state_t  st_r, st_nxt;
	fcs_op_t     op_r, op_nxt;
	logic [2:0]  step_r, step_nxt;
	logic [18:0] adr_r, adr_nxt;
	logic [7:0]  dat_r, dat_nxt;
	logic [7:0]  rd_r, rd_nxt;
	logic        done_r, done_nxt, fail_r, fail_nxt, tmo_r, tmo_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [31:0] poll_r, poll_nxt;
	fcs_pins_t   pin_r, pin_nxt;
	logic [31:0] wbd_r, wbd_nxt;
	logic        ack_r, ack_nxt;
	logic [7:0]  dq_m_r, dq_s_r;
	logic [28:0] sw;
	logic        wb_req, busy;

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign busy   = (st_r != S_IDLE);
	assign sw     = step_word(op_r, step_r, adr_r, dat_r);

	// two-stage synchroniser on the flash data pins
	always_ff @(posedge clk_i) begin
		dq_m_r <= flash_dq_i;
		dq_s_r <= dq_m_r;
	end

	// next-state logic: bus slave and flash sequencer
	always_comb begin
		st_nxt = st_r; op_nxt = op_r; step_nxt = step_r; adr_nxt = adr_r; dat_nxt = dat_r;
		rd_nxt = rd_r; done_nxt = done_r; fail_nxt = fail_r; tmo_nxt = tmo_r;
		cnt_nxt = cnt_r; poll_nxt = poll_r; pin_nxt = pin_r; wbd_nxt = wbd_r;
		ack_nxt = 1'b0;
		// wishbone slave, one wait cycle, unmapped reads zero
		if (wb_req) begin
			ack_nxt = 1'b1;
			case (wb_adr_i)
				`FCS_REG_STAT: wbd_nxt = {16'h0000, rd_r, 4'h0, tmo_r, fail_r, done_r, busy};
				`FCS_REG_ADDR: wbd_nxt = {13'h0000, adr_r};
				`FCS_REG_DATA: wbd_nxt = {24'h000000, dat_r};
				`FCS_REG_CTRL: wbd_nxt = {28'h0000000, 1'b0, op_r};
				default:       wbd_nxt = 32'h00000000;
			endcase
			if (wb_we_i && wb_sel_i[0] && !busy) begin
				if (wb_adr_i == `FCS_REG_ADDR)
					adr_nxt = wb_dat_i[18:0];
				if (wb_adr_i == `FCS_REG_DATA)
					dat_nxt = wb_dat_i[7:0];
				if (wb_adr_i == `FCS_REG_CTRL && wb_sel_i[1] && wb_dat_i[`FCS_CTRL_GO]) begin
					op_nxt   = fcs_op_t'(wb_dat_i[`FCS_CTRL_OP_MSB:`FCS_CTRL_OP_LSB]);
					step_nxt = (wb_dat_i[2:0] == 3'd0 || wb_dat_i[2:0] > 3'd5) ? 3'd5 : 3'd0;
					st_nxt   = S_SETUP;
					done_nxt = 1'b0; fail_nxt = 1'b0; tmo_nxt = 1'b0;
				end
			end
		end
		case (st_r)
			S_IDLE: ;
			// address, chip select and write or read strobe all set in the same cycle
			S_SETUP: begin
				pin_nxt.ce_n = 1'b0; pin_nxt.addr = sw[26:8];
				pin_nxt.dout = sw[7:0]; pin_nxt.doe = ~sw[27];
				cnt_nxt = 32'd`FCS_GAP_CYC; st_nxt = S_STROBE;
				if (sw[27]) pin_nxt.oe_n = 1'b0; else pin_nxt.we_n = 1'b0;
			end
			S_STROBE: begin
				cnt_nxt = cnt_r - 32'd1;
				if (cnt_r == 32'd1) begin
					pin_nxt.we_n = 1'b1; pin_nxt.oe_n = 1'b1;
					if (sw[27]) rd_nxt = dq_s_r;
					st_nxt = S_HOLD; cnt_nxt = 32'd`FCS_GAP_CYC;
				end
			end
			S_HOLD: begin
				cnt_nxt = cnt_r - 32'd1;
				if (cnt_r == 32'd1) begin
					pin_nxt.ce_n = 1'b1; pin_nxt.doe = 1'b0;
					step_nxt = step_r + 3'd1;
					poll_nxt = 32'd0;
					if (sw[28] && (op_r == FCS_OP_PROG || op_r == FCS_OP_CHIP || op_r == FCS_OP_SECT))
						st_nxt = S_POLL;
					else if (sw[28]) begin
						st_nxt = S_IDLE; done_nxt = 1'b1;
					end else
						st_nxt = S_GAP;
					cnt_nxt = 32'd`FCS_GAP_CYC;
				end
			end
			// short fixed gap keeps writes inside window
			S_GAP: begin
				cnt_nxt = cnt_r - 32'd1;
				if (cnt_r == 32'd1) st_nxt = S_SETUP;
			end
			// poll reads at the latched location
			S_POLL: begin
				// total cycles spent polling, cleared on entry
				poll_nxt = poll_r + 32'd1;
				if (pin_r.oe_n) begin
					pin_nxt.ce_n = 1'b0; pin_nxt.oe_n = 1'b0; pin_nxt.addr = adr_r;
					cnt_nxt = 32'd`FCS_GAP_CYC;
				end else if (cnt_r != 32'd0) begin
					cnt_nxt = cnt_r - 32'd1;
				end else begin
					pin_nxt.ce_n = 1'b1; pin_nxt.oe_n = 1'b1;
					rd_nxt = dq_s_r;
					// erase done when status bit is one
					if ((op_r == FCS_OP_PROG && dq_s_r[`FCS_POLL_BIT] == dat_r[`FCS_POLL_BIT]) ||
					    (op_r != FCS_OP_PROG && dq_s_r[`FCS_POLL_BIT])) begin
						st_nxt = S_IDLE; done_nxt = 1'b1;
					end else if (dq_s_r[`FCS_TLIM_BIT]) begin
						st_nxt = S_IDLE; fail_nxt = 1'b1; done_nxt = 1'b1;
					// bounded wait, silent flash gives up
					end else if (poll_r >= `FCS_POLL_LIMIT) begin
						st_nxt = S_IDLE; tmo_nxt = 1'b1; fail_nxt = 1'b1; done_nxt = 1'b1;
					end
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	// register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= S_IDLE; op_r <= FCS_OP_READ; step_r <= 3'd0; adr_r <= 19'h00000;
			dat_r <= 8'h00; rd_r <= 8'h00; done_r <= 1'b0; fail_r <= 1'b0; tmo_r <= 1'b0;
			cnt_r <= 32'd0; poll_r <= 32'd0; wbd_r <= 32'h00000000; ack_r <= 1'b0;
			pin_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 19'h00000, dout: 8'h00, doe: 1'b0};
		end else begin
			st_r <= st_nxt; op_r <= op_nxt; step_r <= step_nxt; adr_r <= adr_nxt;
			dat_r <= dat_nxt; rd_r <= rd_nxt; done_r <= done_nxt; fail_r <= fail_nxt;
			tmo_r <= tmo_nxt; cnt_r <= cnt_nxt; poll_r <= poll_nxt; pin_r <= pin_nxt;
			wbd_r <= wbd_nxt; ack_r <= ack_nxt;
		end
	end

	assign wb_dat_o = wbd_r;
	assign wb_ack_o = ack_r;
	assign flash_o  = pin_r;
endmodule : fcs_host

// file: test/fcs_host_assertions.sv
// fcs_host_assertions.sv: bus and flash pin protocol checks on the flash host
// assumes: bound into fcs_host, one clock, synchronous reset
`timescale 1ns/1ps
module fcs_host_chk (
	// clock and reset
	input wire logic               clk_i,
	input wire logic               rst_i,
	// watched ports
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_ack_o,
	input wire fcs_pkg::fcs_pins_t flash_o
);
	import fcs_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_wce; !flash_o.we_n |-> !flash_o.ce_n; endproperty
	a_wce: assert property (p_wce) else $error("write strobe without select");
	property p_rw; flash_o.we_n || flash_o.oe_n; endproperty
	a_rw: assert property (p_rw) else $error("both strobes low");
	property p_hold; !flash_o.we_n && !$past(flash_o.we_n)
		|-> $stable(flash_o.addr) && $stable(flash_o.dout); endproperty
	a_hold: assert property (p_hold) else $error("address or data moved in strobe");
	property p_wide; $fell(flash_o.we_n) |-> !flash_o.we_n [*8]; endproperty
	a_wide: assert property (p_wide) else $error("write strobe too short");
	property p_odrv; !flash_o.oe_n |-> !flash_o.doe && !flash_o.ce_n; endproperty
	a_odrv: assert property (p_odrv) else $error("data driven during read");
	property p_unl1; $fell(flash_o.we_n) && flash_o.dout == 8'haa |-> flash_o.addr == 19'h05555; endproperty
	a_unl1: assert property (p_unl1) else $error("first unlock address");
	property p_unl2; $fell(flash_o.we_n) && flash_o.dout == 8'h55 |-> flash_o.addr == 19'h02aaa; endproperty
	a_unl2: assert property (p_unl2) else $error("second unlock address");
endmodule : fcs_host_chk
bind fcs_host fcs_host_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .flash_o(flash_o));

// file: test/fcs_flash_model.sv
// fcs_flash_model.sv: behavioural byte-wide flash seen through its pins
// assumes: host strobes short next to the internal timers
`timescale 1ns/1ps
module fcs_flash_model #(
	parameter logic [7:0] MAKER_ID = 8'h2a, // arbitrary value, odd parity
	parameter logic [7:0] DEV_ID   = 8'hc2  // arbitrary value, odd parity
) (
	// host pins
	input  wire fcs_pkg::fcs_pins_t pins_i,
	output logic [7:0]              dq_o
);
	import fcs_pkg::*;
	logic [7:0]  mem [logic [18:0]];
	logic [18:0] lat_a;
	logic [7:0]  pv, sec, drv = 8'h00;
	logic        id_m = 1'b0, busy = 1'b0, win = 1'b0, er = 1'b0, tlim = 1'b0;
	int          step = 0;
	realtime     tend;
	assign dq_o = drv;
	// array byte, erased when never written
	function automatic logic [7:0] rd(input logic [18:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction : rd
	// embedded erase of the sectors in a mask
	task automatic run_erase(input logic [7:0] m);
		busy = 1'b1;
		er = 1'b1;
		fork begin
			#20000;
			foreach (mem[k]) if (m[k[18:16]]) mem[k] = 8'hff;
			busy = 1'b0;
			er = 1'b0;
		end join_none
	endtask : run_erase
	// command state machine, one call per write
	task automatic take(input logic [18:0] a, input logic [7:0] d);
		if (d == 8'hf0 && (!busy || tlim)) begin
			step = 0;
			id_m = 1'b0;
			busy = 1'b0;
			tlim = 1'b0;
			win = 1'b0;
			return;
		end
		if (busy) return;
		// stray suspend or resume outside erase is harmless
		if (step == 0 && (d == 8'hb0 || d == 8'h30)) return;
		case (step)
			0, 3: step = (a[14:0] == 15'h5555 && d == 8'haa) ? step + 1 : 0;
			1, 4: step = (a[14:0] == 15'h2aaa && d == 8'h55) ? step + 1 : 0;
			2: begin
				id_m = (d == 8'h90);
				step = (d == 8'ha0) ? 6 : (d == 8'h80) ? 3 : 0;
			end
			6: begin
				pv = d;
				busy = 1'b1;
				tlim = |(d & ~rd(a));
				step = 0;
				if (!tlim) fork begin #2000; mem[a] = d; busy = 1'b0; end join_none
			end
			5: begin
				step = 0;
				if (d == 8'h10 && a[14:0] == 15'h5555) run_erase(8'hff);
				if (d == 8'h30) begin
					sec = 8'h01 << a[18:16];
					win = 1'b1;
					step = 7;
					tend = $realtime + 80000;
					fork begin
						while ($realtime < tend) #100;
						if (win) begin win = 1'b0; step = 0; run_erase(sec); end
					end join_none
				end
			end
			7: begin
				// add sector and restart timer, or abort
				if (d == 8'h30) begin sec[a[18:16]] = 1'b1; tend = $realtime + 80000; end
				else begin win = 1'b0; step = 0; end
			end
			default: step = 0;
		endcase
	endtask : take
	always @(negedge pins_i.we_n or negedge pins_i.ce_n)
		if (!pins_i.we_n && !pins_i.ce_n) lat_a = pins_i.addr;
	always @(posedge pins_i.we_n)
		if (!pins_i.ce_n) take(lat_a, pins_i.dout);
	// read path; released bus keeps flipping
	always @(pins_i, busy, win, id_m) begin
		if (pins_i.ce_n || pins_i.oe_n) drv = ~drv;
		else if (busy || win) drv = {(er || win) ? 1'b0 : ~pv[7], 1'b0, tlim, 5'h00};
		else if (id_m) drv = pins_i.addr[1] ? 8'h00 : pins_i.addr[0] ? DEV_ID : MAKER_ID;
		else drv = rd(pins_i.addr);
	end
endmodule : fcs_flash_model

// file: test/testbench.sv
// testbench.sv: wishbone scenarios driving the flash host into the flash model
// assumes: fcs_map.svh on the include path
`timescale 1ns/1ps
`include "fcs_map.svh"
module testbench;
	import fcs_pkg::*;
	localparam logic [7:0] MID = 8'h2a; // arbitrary value
	localparam logic [7:0] DID = 8'hc2; // arbitrary value
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, stat;
	logic [7:0]  dq, dq_m;
	fcs_pins_t   pins;
	int          err_count = 0, comparisons = 0, cycles = 0;
	always #12.5 clk_i = ~clk_i;
	// wire level from both drivers
	assign dq = pins.doe ? pins.dout : dq_m;
	fcs_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .flash_o(pins), .flash_dq_i(dq));
	fcs_flash_model #(.MAKER_ID(MID), .DEV_ID(DID)) flash_u (.pins_i(pins), .dq_o(dq_m));
	task automatic test_done;
		$display("counts: %0d compared, %0d mismatched", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle, held until ack
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		stat = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	// order an operation and poll until idle
	task automatic op(input logic [2:0] o, input logic [18:0] a, input logic [7:0] d);
		wb(1'b1, `FCS_REG_ADDR, {13'h0, a});
		wb(1'b1, `FCS_REG_DATA, {24'h0, d});
		wb(1'b1, `FCS_REG_CTRL, {23'h0, 1'b1, 5'h0, o});
		do wb(1'b0, `FCS_REG_STAT, 32'h0); while (stat[`FCS_STAT_BUSY] !== 1'b0);
	endtask : op
	task automatic rd(input logic [18:0] a, input logic [7:0] e);
		op(3'd0, a, 8'h00);
		chk({24'h0, stat[15:8]}, {24'h0, e});
	endtask : rd
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 4'h2, 32'h0);
		chk(stat, 32'h0);
		rd(19'h12345, 8'hff);
		op(3'd2, 19'h0, 8'h00);
		rd(19'h70000, MID);
		rd(19'h00001, DID);
		chk({31'h0, ^stat[15:8]}, 32'h1);
		rd(19'h30002, 8'h00);
		op(3'd1, 19'h0, 8'h00);
		rd(19'h12345, 8'hff);
		op(3'd3, 19'h12345, 8'h3c);
		chk({29'h0, stat[3:1]}, 32'h1);
		rd(19'h12345, 8'h3c);
		op(3'd3, 19'h12345, 8'hc3);
		chk({31'h0, stat[`FCS_STAT_FAIL]}, 32'h1);
		op(3'd1, 19'h0, 8'h00);
		rd(19'h12345, 8'h3c);
		op(3'd5, 19'h1ffff, 8'h00);
		rd(19'h12345, 8'hff);
		op(3'd3, 19'h40000, 8'h0f);
		wb(1'b0, `FCS_REG_ADDR, 32'h0);
		chk(stat, 32'h00040000);
		wb(1'b0, `FCS_REG_DATA, 32'h0);
		chk(stat, 32'h0000000f);
		rd(19'h40000, 8'h0f);
		op(3'd4, 19'h0, 8'h00);
		op(3'd6, 19'h0, 8'h00);
		op(3'd7, 19'h0, 8'h00);
		wb(1'b0, `FCS_REG_CTRL, 32'h0);
		chk(stat, 32'h00000007);
		rd(19'h40000, 8'hff);
		test_done();
	end
endmodule : testbench
